/* phs_top.sv */
// Behaviour
// - Status bits 17.7 and 17.6 show strapped MII or RMII back-to-back mode.
// - Status bit 17.5 shows strapped pin connectivity test chain mode.
// - Status bits 17.1 and 17.0 show strapped RMII or MII host mode.
// - Bit 18.11 disables energy-detect power-down when 1; read-write, resets to 1.
// - Bit 18.10 picks random (1) or fixed (0) 100 Mb/s latency; resets 0.
// - Every received preamble byte reaches the MII in 100 Mb/s operation.
// - Bit 18.6 set keeps the 10 Mb/s preamble ahead of the frame.
// - Bit 18.6 clear strips seven preamble bytes; frame starts at SFD.
// - Enable 1B.15, reset 0, lets jabber events drive the interrupt.
// - Enable 1B.14, reset 0, lets receive error events raise the interrupt.
// - Enable 1B.13, reset 0, lets page received events raise the interrupt.
// - Enable 1B.12, reset 0, lets parallel detect faults raise the interrupt.
// - Enable 1B.11, reset 0, lets link partner acknowledge raise the interrupt.
// - Each event latches a sticky status bit cleared when software reads it.
module phs_top
    import phs_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Management pins
    input  wire logic                  mdc,
    input  wire logic                  mdioIn,
    output logic                       mdioOut,
    output logic                       mdioOe,
    // Strap pins
    input  wire logic [STRAP_W-1:0]    strapPins,
    // Events from the PHY core, one-cycle pulses
    input  wire logic [INT_EVENTS-1:0] intEvents,
    // Interrupt pin
    output logic                       intrN,
    // Controls to the PHY core
    output logic                       edpdDisable,
    output logic                       latRandom,
    // Receive path toward the MII
    input  wire logic                  speed10,
    input  wire logic                  rxDvIn,
    input  wire logic [3:0]            rxdIn,
    output logic                       rxDvOut,
    output logic [3:0]                 rxdOut
);
    logic [STRAP_W-1:0]    strapSync1_ff;
    logic [STRAP_W-1:0]    strapSync2_ff;
    logic [STRAP_W-1:0]    strap_ff;
    logic                  strapDone_ff;
    logic [15:0]           ctrl_ff;
    logic [7:0]            intEn_ff;
    logic [INT_EVENTS-1:0] intStat_ff;
    logic                  intrN_ff;
    logic [3:0]            preCnt_ff;
    logic                  rxDv_ff;
    logic [3:0]            rxd_ff;
    logic [4:0]            regAddr;
    logic [15:0]           rdData;
    logic                  rdStb;
    logic                  wrStb;
    logic [15:0]           wrData;

    phs_mdio #(
        .PHY_ADDR (PHY_ADDR)
    ) u_mdio (
        .clk     (clk),
        .rst     (rst),
        .mdc     (mdc),
        .mdioIn  (mdioIn),
        .mdioOut (mdioOut),
        .mdioOe  (mdioOe),
        .regAddr (regAddr),
        .rdStb   (rdStb),
        .rdData  (rdData),
        .wrStb   (wrStb),
        .wrData  (wrData)
    );

    // Address decode and readback
    wire        selStrap = (regAddr == REG_STRAP_STATUS);
    wire        selCtrl  = (regAddr == REG_EXP_CTRL);
    wire        selInt   = (regAddr == REG_INT_CS);
    wire        wrCtrl   = wrStb & selCtrl;
    wire        wrInt    = wrStb & selInt;
    wire        rdInt    = rdStb & selInt;
    wire [15:0] strapWord = {8'h00,
                             strap_ff[STP_B2B_MII], strap_ff[STP_B2B_RMII], strap_ff[STP_CHAIN],
                             3'h0, strap_ff[STP_RMII], strap_ff[STP_MII]};
    wire [15:0] intWord  = {intEn_ff, intStat_ff};
    assign rdData = selStrap ? strapWord :
                    selCtrl  ? ctrl_ff :
                    selInt   ? intWord : 16'h0000;

    // Synchroniser left unreset so it already holds the pins at release
    always_ff @(posedge clk) begin
        strapSync1_ff <= strapPins;
        strapSync2_ff <= strapSync1_ff;
    end

    // Strap pins are asynchronous; captured once just after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_ff      <= '0;
            strapDone_ff  <= 1'b0;
        end else begin
            strapDone_ff  <= 1'b1;
            if (strapDone_ff == 1'b0) begin
                strap_ff <= strapSync2_ff;
            end
        end
    end

    // Control and interrupt registers
    wire [INT_EVENTS-1:0] nxt_intStat = (rdInt ? '0 : intStat_ff) | intEvents;
    wire                  intAny      = |(intStat_ff & intEn_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff    <= EXP_CTRL_RESET;
            intEn_ff   <= INT_CS_RESET[15:INT_EN_LSB];
            intStat_ff <= INT_CS_RESET[INT_EVENTS-1:0];
            intrN_ff   <= 1'b1;
        end else begin
            if (wrCtrl) begin
                ctrl_ff <= wrData;
            end
            if (wrInt) begin
                intEn_ff <= wrData[15:INT_EN_LSB];
            end
            intStat_ff <= nxt_intStat;
            intrN_ff   <= ~intAny;
        end
    end

    // Receive path: one register stage, preamble stripped only at 10 Mb/s
    wire stripOn  = speed10 & ~ctrl_ff[BIT_PRE_RESTORE];
    wire inPre    = rxDvIn & (preCnt_ff < STRIP_NIBBLES);
    wire passDv   = rxDvIn & ~(stripOn & inPre);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preCnt_ff <= 4'h0;
            rxDv_ff   <= 1'b0;
            rxd_ff    <= 4'h0;
        end else begin
            if (!rxDvIn) begin
                preCnt_ff <= 4'h0;
            end else if (inPre) begin
                preCnt_ff <= preCnt_ff + 4'h1;
            end
            rxDv_ff <= passDv;
            rxd_ff  <= passDv ? rxdIn : 4'h0;
        end
    end

    assign intrN       = intrN_ff;
    assign edpdDisable = ctrl_ff[BIT_ENERGY_DETECT_POWER_DOWN_DIS];
    assign latRandom   = ctrl_ff[BIT_LAT_RANDOM];
    assign rxDvOut     = rxDv_ff;
    assign rxdOut      = rxd_ff;

    // Checks
    AST_STRAP: assert property (@(posedge clk) disable iff (rst)
        (strapDone_ff && $past(strapDone_ff)) |-> (strapWord[BIT_B2B_MII] == strap_ff[STP_B2B_MII]) &&
                         (strapWord[BIT_B2B_RMII] == strap_ff[STP_B2B_RMII]) &&
                         (strapWord[BIT_TEST_CHAIN] == strap_ff[STP_CHAIN]) &&
                         (strapWord[BIT_RMII] == strap_ff[STP_RMII]) &&
                         (strapWord[BIT_MII] == strap_ff[STP_MII]) && $stable(strap_ff))
        else $error("Strap status changed after capture");
    AST_ENERGY_DETECT_POWER_DOWN: assert property (@(posedge clk) disable iff (rst)
        wrCtrl |=> (edpdDisable == $past(wrData[BIT_ENERGY_DETECT_POWER_DOWN_DIS])))
        else $error("Power-down disable did not follow write");
    AST_LAT: assert property (@(posedge clk) disable iff (rst)
        !wrCtrl |=> $stable(latRandom))
        else $error("Latency select changed without a write");
    AST_PASS100: assert property (@(posedge clk) disable iff (rst)
        !speed10 |=> (rxDvOut == $past(rxDvIn)))
        else $error("Nibble lost at 100 Mb/s");
    AST_RESTORE: assert property (@(posedge clk) disable iff (rst)
        (speed10 && ctrl_ff[BIT_PRE_RESTORE] && rxDvIn) |=> rxDvOut && (rxdOut == $past(rxdIn)))
        else $error("Preamble not restored at 10 Mb/s");
    sequence seqFrameStart;
        !rxDvIn ##1 rxDvIn;
    endsequence
    AST_STRIP: assert property (@(posedge clk) disable iff (rst)
        (seqFrameStart and (speed10 && !ctrl_ff[BIT_PRE_RESTORE])[*2]) |=> !rxDvOut)
        else $error("Preamble nibble passed while stripping");
    AST_ENABLE: assert property (@(posedge clk) disable iff (rst)
        wrInt |=> (intEn_ff == $past(wrData[15:INT_EN_LSB])))
        else $error("Interrupt enables did not follow write");
    AST_CLR: assert property (@(posedge clk) disable iff (rst)
        (rdInt && intEvents == '0) |=> (intStat_ff == '0))
        else $error("Status not cleared by read");
    AST_SET: assert property (@(posedge clk) disable iff (rst)
        (intEvents[0]) |=> intStat_ff[0])
        else $error("Event lost");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (intrN == !$past(intAny)))
        else $error("Interrupt pin does not follow enabled status");
endmodule

/* phs_pkg.sv */
package phs_pkg;
    // Register addresses on the management bus
    localparam logic [4:0]  REG_STRAP_STATUS = 5'h17;
    localparam logic [4:0]  REG_EXP_CTRL     = 5'h18;
    localparam logic [4:0]  REG_INT_CS       = 5'h1B;

    // Strap status bit positions
    localparam int          BIT_B2B_MII      = 7;
    localparam int          BIT_B2B_RMII     = 6;
    localparam int          BIT_TEST_CHAIN   = 5;
    localparam int          BIT_RMII         = 1;
    localparam int          BIT_MII          = 0;

    // Expanded control bit positions and reset value
    localparam int          BIT_ENERGY_DETECT_POWER_DOWN_DIS     = 11;
    localparam int          BIT_LAT_RANDOM   = 10;
    localparam int          BIT_PRE_RESTORE  = 6;
    localparam logic [15:0] EXP_CTRL_RESET   = 16'h0801;

    // Interrupt register: enables high byte, sticky status low byte
    localparam int          INT_EN_LSB       = 8;
    localparam int          INT_EVENTS       = 8;
    localparam logic [15:0] INT_CS_RESET     = 16'h0000;

    // Strap pin vector order
    localparam int          STRAP_W          = 5;
    localparam int          STP_MII          = 0;
    localparam int          STP_RMII         = 1;
    localparam int          STP_CHAIN        = 2;
    localparam int          STP_B2B_RMII     = 3;
    localparam int          STP_B2B_MII      = 4;

    // Seven preamble bytes, two nibbles each on the MII
    localparam logic [3:0]  STRIP_NIBBLES    = 4'hE;

    // Management frame
    localparam logic [5:0]  PRE_LEN          = 6'h20;
    localparam logic [4:0]  HDR_LAST         = 5'h0C;
    localparam logic [4:0]  DATA_LAST        = 5'h0F;
    localparam logic [1:0]  OP_WRITE         = 2'h1;
    localparam logic [1:0]  OP_READ          = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR  = 4'h2,
        ST_TA   = 4'h4,
        ST_DATA = 4'h8
    } phs_mstate_t;
endpackage

/* phs_mdio.sv */
module phs_mdio
    import phs_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Management pins
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    output logic             mdioOut,
    output logic             mdioOe,
    // Register access
    output logic [4:0]       regAddr,
    output logic             rdStb,
    input  wire logic [15:0] rdData,
    output logic             wrStb,
    output logic [15:0]      wrData
);
    phs_mstate_t state_ff;
    logic [2:0]  mdcSync_ff;
    logic [1:0]  dioSync_ff;
    logic [5:0]  ones_ff;
    logic [4:0]  cnt_ff;
    logic [12:0] hdr_ff;
    logic [15:0] sh_ff;
    logic        isRead_ff;
    logic        rdStb_ff;
    logic        wrStb_ff;
    logic        oe_ff;
    logic        out_ff;
    logic [4:0]  addr_ff;

    // Bit value and MDC rise, both read only after the second stage
    wire        bitIn   = dioSync_ff[1];
    wire        mdcRise = mdcSync_ff[1] & ~mdcSync_ff[2];
    wire [12:0] hdrFull = {hdr_ff[11:0], bitIn};
    wire        hdrOk   = hdrFull[12] & (hdrFull[9:5] == PHY_ADDR);
    wire [1:0]  hdrOp   = hdrFull[11:10];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdcSync_ff <= 3'h0;
            dioSync_ff <= 2'h3;
        end else begin
            mdcSync_ff <= {mdcSync_ff[1:0], mdc};
            dioSync_ff <= {dioSync_ff[0], mdioIn};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff  <= ST_IDLE;
            ones_ff   <= 6'h00;
            cnt_ff    <= 5'h00;
            hdr_ff    <= 13'h0000;
            sh_ff     <= 16'h0000;
            isRead_ff <= 1'b0;
            rdStb_ff  <= 1'b0;
            wrStb_ff  <= 1'b0;
            oe_ff     <= 1'b0;
            out_ff    <= 1'b0;
            addr_ff   <= 5'h00;
        end else begin
            rdStb_ff <= 1'b0;
            wrStb_ff <= 1'b0;
            // Read data captured in the strobe cycle, before clear-on-read lands
            if (rdStb_ff) begin
                sh_ff <= rdData;
            end
            if (mdcRise) begin
                case (state_ff)
                    ST_IDLE: begin
                        if (bitIn) begin
                            if (ones_ff != PRE_LEN) begin
                                ones_ff <= ones_ff + 6'h01;
                            end
                        end else begin
                            ones_ff <= 6'h00;
                            if (ones_ff == PRE_LEN) begin
                                state_ff <= ST_HDR;
                                cnt_ff   <= 5'h00;
                            end
                        end
                    end
                    ST_HDR: begin
                        hdr_ff <= hdrFull;
                        cnt_ff <= cnt_ff + 5'h01;
                        if (cnt_ff == HDR_LAST) begin
                            cnt_ff    <= 5'h00;
                            addr_ff   <= hdrFull[4:0];
                            isRead_ff <= (hdrOp == OP_READ);
                            if (hdrOk && (hdrOp == OP_READ || hdrOp == OP_WRITE)) begin
                                state_ff <= ST_TA;
                                rdStb_ff <= (hdrOp == OP_READ);
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end
                    end
                    ST_TA: begin
                        cnt_ff <= cnt_ff + 5'h01;
                        if (cnt_ff == 5'h00) begin
                            oe_ff  <= isRead_ff;
                            out_ff <= 1'b0;
                        end else begin
                            state_ff <= ST_DATA;
                            cnt_ff   <= 5'h00;
                            if (isRead_ff) begin
                                out_ff <= sh_ff[15];
                                sh_ff  <= {sh_ff[14:0], 1'b0};
                            end
                        end
                    end
                    ST_DATA: begin
                        cnt_ff <= cnt_ff + 5'h01;
                        if (isRead_ff) begin
                            out_ff <= sh_ff[15];
                            sh_ff  <= {sh_ff[14:0], 1'b0};
                        end else begin
                            sh_ff <= {sh_ff[14:0], bitIn};
                        end
                        if (cnt_ff == DATA_LAST) begin
                            state_ff <= ST_IDLE;
                            oe_ff    <= 1'b0;
                            wrStb_ff <= ~isRead_ff;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign mdioOut = out_ff;
    assign mdioOe  = oe_ff;
    assign regAddr = addr_ff;
    assign rdStb   = rdStb_ff;
    assign wrStb   = wrStb_ff;
    assign wrData  = sh_ff;
endmodule

/* phs_host.sv */
module phs_host
    import phs_pkg::*;
(
    // Management pins
    output logic      mdc,
    output logic      hostOut,
    output logic      hostOe,
    input  wire logic mdio
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: clock stands low, line released to the pull-up
    initial begin
        mdc     = 1'b0;
        hostOut = 1'b1;
        hostOe  = 1'b0;
    end

    // 10 MHz bit: data set while mdc low, held across the rise
    task automatic put_bit(input logic b, input logic oe, output logic smp);
        hostOut = b;
        hostOe  = oe;
        #50 mdc = 1'b1;
        smp = mdio;
        #50 mdc = 1'b0;
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdv);
        logic [13:0] hdr;
        logic        s;
        hdr = {2'b01, op, phy, ra};
        rdv = 16'h0000;
        for (int i = 0; i < 32; i++) put_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) put_bit(hdr[i], 1'b1, s);
        if (op == OP_READ) begin
            put_bit(1'b1, 1'b0, s);
            put_bit(1'b1, 1'b0, s);
            for (int i = 15; i >= 0; i--) put_bit(1'b1, 1'b0, rdv[i]);
        end else begin
            put_bit(1'b1, 1'b1, s);
            put_bit(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--) put_bit(wd[i], 1'b1, s);
        end
        // Extra released bit so the device can drop its drive
        put_bit(1'b1, 1'b0, s);
    endtask
endmodule

/* phs_top_tb.sv */
module phs_top_tb
    import phs_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic                  clk;
    logic                  rst;
    logic [STRAP_W-1:0]    strapPins;
    logic [INT_EVENTS-1:0] intEvents;
    logic                  speed10;
    logic                  rxDvIn;
    logic [3:0]            rxdIn;
    logic                  mdc;
    logic                  hostOut;
    logic                  hostOe;
    logic                  mdioOut;
    logic                  mdioOe;
    logic                  intrN;
    logic                  edpdDisable;
    logic                  latRandom;
    logic                  rxDvOut;
    logic [3:0]            rxdOut;
    logic [3:0]            rxSeen[$];
    int                    n_mismatch;
    int                    cmp_count;
    // Pull-up on the shared line
    wire                   mdio = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);

    phs_top #(.PHY_ADDR(5'h01)) u_dut (
        .clk         (clk),
        .rst         (rst),
        .mdc         (mdc),
        .mdioIn      (mdio),
        .mdioOut     (mdioOut),
        .mdioOe      (mdioOe),
        .strapPins   (strapPins),
        .intEvents   (intEvents),
        .intrN       (intrN),
        .edpdDisable (edpdDisable),
        .latRandom   (latRandom),
        .speed10     (speed10),
        .rxDvIn      (rxDvIn),
        .rxdIn       (rxdIn),
        .rxDvOut     (rxDvOut),
        .rxdOut      (rxdOut)
    );

    phs_host u_host (.mdc(mdc), .hostOut(hostOut), .hostOe(hostOe), .mdio(mdio));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Sampled mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (rxDvOut === 1'b1) rxSeen.push_back(rxdOut);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] d;
        u_host.frame(OP_READ, 5'h01, ra, 16'h0000, d);
        tick(1);
        check(what, exp, d);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] unused;
        u_host.frame(OP_WRITE, 5'h01, ra, d, unused);
        tick(1);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Straps are only sampled at reset release, so each pattern needs a reset
    task automatic t_reset(input logic [STRAP_W-1:0] s);
        logic [15:0] sx;
        logic [15:0] d;
        rst = 1'b1;
        strapPins = s;
        tick(16);
        rst = 1'b0;
        tick(4);
        sx = 16'h0000;
        sx[7] = s[STP_B2B_MII];
        sx[6] = s[STP_B2B_RMII];
        sx[5] = s[STP_CHAIN];
        sx[1] = s[STP_RMII];
        sx[0] = s[STP_MII];
        check("energy_detect_power_down pin", 16'h0001, {15'h0, edpdDisable});
        check("latency pin", 16'h0000, {15'h0, latRandom});
        rd_chk("strap status", REG_STRAP_STATUS, sx);
        wr(REG_STRAP_STATUS, ~sx);
        rd_chk("strap after write", REG_STRAP_STATUS, sx);
        rd_chk("ctrl reset", REG_EXP_CTRL, 16'h0801);
        rd_chk("int reset", REG_INT_CS, 16'h0000);
        rd_chk("unmapped", 5'h10, 16'h0000);
        u_host.frame(OP_READ, 5'h02, REG_EXP_CTRL, 16'h0000, d);
        tick(1);
        check("other address", 16'hFFFF, d);
        $display("test reset %b done", s);
    endtask

    task automatic t_ctrl;
        logic [15:0] v[3] = '{16'h0000, 16'h0440, 16'h0840};
        foreach (v[k]) begin
            wr(REG_EXP_CTRL, v[k]);
            rd_chk("ctrl readback", REG_EXP_CTRL, v[k]);
            check("energy_detect_power_down pin", {15'h0, v[k][11]}, {15'h0, edpdDisable});
            check("latency pin", {15'h0, v[k][10]}, {15'h0, latRandom});
        end
        $display("test ctrl done");
    endtask

    task automatic t_irq;
        wr(REG_INT_CS, 16'hF8FF);
        rd_chk("enables", REG_INT_CS, 16'hF800);
        for (int i = 0; i < INT_EVENTS; i++) begin
            intEvents = 8'h01 << i;
            tick(1);
            intEvents = 8'h00;
            tick(3);
            // Only events 7..3 have their enable set here
            check("irq pin", {15'h0, i < 3}, {15'h0, intrN});
            rd_chk("event latched", REG_INT_CS, 16'hF800 | (16'h0001 << i));
            check("irq released", 16'h0001, {15'h0, intrN});
            rd_chk("status cleared", REG_INT_CS, 16'hF800);
        end
        wr(REG_INT_CS, 16'h0000);
        intEvents = 8'hFF;
        tick(1);
        intEvents = 8'h00;
        tick(3);
        check("irq masked", 16'h0001, {15'h0, intrN});
        rd_chk("masked latched", REG_INT_CS, 16'h00FF);
        $display("test irq done");
    endtask

    task automatic t_rx(input logic sp, input logic [15:0] ctrl, input int skip);
        logic [3:0] nib[20];
        for (int k = 0; k < 20; k++) nib[k] = (k < 15) ? 4'h5 : (k == 15) ? 4'hD : 4'(k);
        wr(REG_EXP_CTRL, ctrl);
        speed10 = sp;
        rxSeen.delete();
        for (int k = 0; k < 20; k++) begin
            rxDvIn = 1'b1;
            rxdIn = nib[k];
            tick(1);
        end
        rxDvIn = 1'b0;
        rxdIn = 4'h0;
        tick(4);
        check("rx count", 16'(20 - skip), 16'(rxSeen.size()));
        for (int k = skip; k < 20; k++) check("rx nibble", {12'h0, nib[k]}, {12'h0, rxSeen[k - skip]});
        $display("test rx speed10=%b ctrl=%h done", sp, ctrl);
    endtask

    initial begin
        rst = 1'b1;
        strapPins = 5'h00;
        intEvents = 8'h00;
        speed10 = 1'b0;
        rxDvIn = 1'b0;
        rxdIn = 4'h0;
        n_mismatch = 0;
        cmp_count = 0;
        t_reset(5'h15);
        t_ctrl;
        t_irq;
        t_rx(1'b0, 16'h0C01, 0);
        t_rx(1'b0, 16'h0801, 0);
        t_rx(1'b1, 16'h0841, 0);
        t_rx(1'b1, 16'h0801, 14);
        t_reset(5'h0A);
        stop_test;
    end

    // About 300 us of management frames expected
    initial begin
        #450us;
        n_mismatch++;
        $display("watchdog expired");
        stop_test;
    end
endmodule
